// >>> sepc_top.sv
/*
 * Three-wire serial EEPROM device: instruction shifter, enable latch,
 * self-timed program/erase cycle, ready/busy polling and read-out.
 * Assumes all pins are synchronous to CLK and the serial clock is much
 * slower than CLK.
 */
// Contract
// - Chip-select fall after a full write starts a clear-then-store cycle.
// - A started cycle finishes on internal timing, no serial clock needed.
// - Host polls busy by raising chip select and sampling data output.
// - Every single write clears its location first by itself.
// - Chip-select fall after erase clears that location to all ones.
// - Enable latch is disabled at power-up.
// - Latch stays set until reset or a disable instruction.
// - With latch cleared, writes and clears are refused.
// - Reads work whatever the latch state.
// - Chip-select fall after erase-all clears the whole array to ones.
// - Chip-select fall after write-all stores the word everywhere.
// - Write-all needs no prior erase-all.
// - While polling, output is low when busy and high when ready.
// - Writes and clears need program enable high; enable/disable ignore it.
// - Instruction is start bit, 2-bit opcode, address, then data.
`timescale 1ns/1ps
module sepc_top
    import sepc_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_CYCLES_DFLT
) (
    input  wire logic CLK,
    input  wire logic RST,
    input  wire logic CHIP_SELECT,
    input  wire logic SERIAL_CLOCK_IN,
    input  wire logic SERIAL_DATA_IN,
    input  wire logic PROGRAM_ENABLE_PIN,
    input  wire logic WORD_WIDTH_SELECT,
    output logic      SERIAL_DATA_OUT,
    output logic      SERIAL_DATA_OUT_OE_N,
    output logic      BUSY,
    output logic      WRITE_ENABLED
);
    localparam int CW = $clog2(PROG_CYCLES + 1);

    function automatic logic [SH_W-1:0] field(input logic [SH_W-1:0] v,
                                              input logic [4:0] lsb,
                                              input logic [4:0] w);
        field = (v >> lsb) & ((SH_W'(1) << w) - SH_W'(1));
    endfunction : field

    function automatic logic pick(input logic [DATA_W-1:0] w,
                                  input logic a0,
                                  input logic word_width_select,
                                  input logic [3:0] idx);
        if (word_width_select) begin
            pick = w[idx];
        end else begin
            pick = w[{a0, idx[2:0]}];
        end
    endfunction : pick

    sepc_mem_if mif ();
    sepc_mem u_mem (
        .clk (CLK),
        .bus (mif.mem)
    );

    sepc_state_e           state;
    logic                  sk_q;
    logic                  cs_q;
    logic [SH_W-1:0]       sreg;
    logic [4:0]            bit_cnt;
    logic                  pend_valid;
    logic [1:0]            pend_kind;
    logic [ADDR_MAX_W-1:0] pend_addr;
    logic [DATA_W-1:0]     pend_data;
    logic                  pend_org;
    logic [CW-1:0]         cnt;
    logic                  poll;
    logic [ADDR_MAX_W-1:0] rd_addr;
    logic [3:0]            rd_idx;
    logic                  rd_org;

    logic                  sk_rise;
    logic                  cs_fall;
    logic [SH_W-1:0]       nxt;
    logic [4:0]            a_w;
    logic [4:0]            d_w;
    logic [4:0]            n;
    logic                  at_addr;
    logic                  at_data;
    logic [1:0]            opc;
    logic [1:0]            sub;
    logic [ADDR_MAX_W-1:0] dec_addr;
    logic [DATA_W-1:0]     dec_data;
    logic                  needs_data;
    logic                  go;
    logic [ADDR_W-1:0]     s_addr;
    logic [LANES-1:0]      s_be;
    logic [DATA_W-1:0]     s_data;
    logic                  sweep;

    // Edge detection on the synchronous pins
    always_ff @(posedge CLK) begin
        if (RST) begin
            sk_q <= 1'b0;
            cs_q <= 1'b0;
        end else begin
            sk_q <= SERIAL_CLOCK_IN;
            cs_q <= CHIP_SELECT;
        end
    end

    // Instruction field decode
    always_comb begin
        sk_rise  = CHIP_SELECT && SERIAL_CLOCK_IN && !sk_q;
        cs_fall  = cs_q && !CHIP_SELECT;
        nxt      = {sreg[SH_W-2:0], SERIAL_DATA_IN};
        a_w      = WORD_WIDTH_SELECT ? ADDR_X16_W : ADDR_X8_W;
        d_w      = WORD_WIDTH_SELECT ? DATA_X16_W : DATA_X8_W;
        n        = bit_cnt + 5'h01;
        at_addr  = state == ST_SHIFT && sk_rise && n == OPC_W + a_w;
        at_data  = state == ST_SHIFT && sk_rise && n == OPC_W + a_w + d_w;
        opc      = 2'(field(nxt, at_data ? d_w + a_w : a_w, OPC_W));
        sub      = 2'(field(nxt, a_w - OPC_W, OPC_W));
        dec_addr = ADDR_MAX_W'(field(nxt, at_data ? d_w : 5'h00, a_w));
        dec_data = DATA_W'(field(nxt, 5'h00, d_w));
        needs_data = opc == OPC_WRITE
                     || (opc == OPC_SPECIAL && sub == SUB_WRITE_ALL_CMD);
    end

    // Frame sequencing
    always_ff @(posedge CLK) begin
        if (RST || !CHIP_SELECT) begin
            state <= ST_IDLE;
        end else if (sk_rise) begin
            unique case (state)
                ST_IDLE: begin
                    if (SERIAL_DATA_IN && !BUSY) begin
                        state <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (at_addr) begin
                        if (opc == OPC_READ) begin
                            state <= ST_READ;
                        end else begin
                            state <= needs_data ? ST_SHIFT : ST_DONE;
                        end
                    end else if (at_data) begin
                        state <= ST_DONE;
                    end
                end
                ST_READ: state <= ST_READ;
                ST_DONE: state <= ST_DONE;
            endcase
        end
    end

    // Bit shifter
    always_ff @(posedge CLK) begin
        if (RST || state != ST_SHIFT) begin
            sreg    <= '0;
            bit_cnt <= 5'h00;
        end else if (sk_rise) begin
            sreg    <= nxt;
            bit_cnt <= n;
        end
    end

    // Pending program or erase instruction
    always_ff @(posedge CLK) begin
        if (RST) begin
            pend_valid <= 1'b0;
            pend_kind  <= K_WRITE;
            pend_addr  <= '0;
            pend_data  <= '0;
            pend_org   <= 1'b0;
        end else if (cs_fall || (state == ST_IDLE && sk_rise)) begin
            pend_valid <= 1'b0;
        end else if (at_addr && !needs_data) begin
            pend_org  <= WORD_WIDTH_SELECT;
            pend_addr <= dec_addr;
            pend_data <= '1;
            if (opc == OPC_ERASE) begin
                pend_valid <= 1'b1;
                pend_kind  <= K_ERASE;
            end else if (opc == OPC_SPECIAL && sub == SUB_ERASE_ALL_CMD) begin
                pend_valid <= 1'b1;
                pend_kind  <= K_ERASE_ALL_CMD;
            end
        end else if (at_data) begin
            pend_valid <= 1'b1;
            pend_org   <= WORD_WIDTH_SELECT;
            pend_addr  <= dec_addr;
            pend_data  <= dec_data;
            pend_kind  <= opc == OPC_WRITE ? K_WRITE : K_WRITE_ALL_CMD;
        end
    end

    // Erase/write enable latch
    always_ff @(posedge CLK) begin
        if (RST) begin
            WRITE_ENABLED <= WEN_RESET;
        end else if (at_addr && opc == OPC_SPECIAL) begin
            if (sub == SUB_ENABLE) begin
                WRITE_ENABLED <= 1'b1;
            end else if (sub == SUB_DISABLE) begin
                WRITE_ENABLED <= 1'b0;
            end
        end
    end

    // Cycle start only on a complete, permitted instruction
    assign go = cs_fall && state == ST_DONE && pend_valid
                && WRITE_ENABLED && PROGRAM_ENABLE_PIN;

    // Self-timed cycle, free of the serial clock
    always_ff @(posedge CLK) begin
        if (RST) begin
            BUSY <= 1'b0;
            cnt  <= '0;
        end else if (go) begin
            BUSY <= 1'b1;
            cnt  <= '0;
        end else if (BUSY) begin
            if (cnt == CW'(PROG_CYCLES - 1)) begin
                BUSY <= 1'b0;
            end else begin
                cnt <= cnt + CW'(1);
            end
        end
    end

    // Array writes during the cycle
    always_comb begin
        s_addr = pend_org ? pend_addr[ADDR_W-1:0] : pend_addr[ADDR_W:1];
        if (pend_org) begin
            s_be   = '1;
            s_data = pend_data;
        end else begin
            s_be   = pend_addr[0] ? 2'h2 : 2'h1;
            s_data = {pend_data[7:0], pend_data[7:0]};
        end
        sweep     = int'(cnt) < MEM_DEPTH;
        mif.wr_en = 1'b0;
        mif.be    = s_be;
        mif.waddr = s_addr;
        mif.wdata = '1;
        mif.raddr = rd_org ? rd_addr[ADDR_W-1:0] : rd_addr[ADDR_W:1];
        if (BUSY) begin
            unique case (pend_kind)
                K_WRITE: begin
                    if (cnt == CW'(PROG_CYCLES - 1)) begin
                        mif.wr_en = 1'b1;
                        mif.wdata = s_data;
                    end else if (cnt == '0) begin
                        mif.wr_en = 1'b1;
                    end
                end
                K_ERASE: mif.wr_en = cnt == '0;
                K_WRITE_ALL_CMD: begin
                    mif.wr_en = sweep;
                    mif.be    = '1;
                    mif.waddr = cnt[ADDR_W-1:0];
                    mif.wdata = s_data;
                end
                K_ERASE_ALL_CMD: begin
                    mif.wr_en = sweep;
                    mif.be    = '1;
                    mif.waddr = cnt[ADDR_W-1:0];
                end
            endcase
        end
    end

    // Ready/busy polling window
    always_ff @(posedge CLK) begin
        if (RST) begin
            poll <= 1'b0;
        end else if (go) begin
            poll <= 1'b1;
        end else if (poll && sk_rise && SERIAL_DATA_IN) begin
            poll <= 1'b0;
        end
    end

    // Sequential read pointer
    always_ff @(posedge CLK) begin
        if (RST) begin
            rd_addr <= '0;
            rd_idx  <= 4'h0;
            rd_org  <= 1'b0;
        end else if (at_addr && opc == OPC_READ) begin
            rd_addr <= dec_addr;
            rd_idx  <= 4'(d_w - 5'h01);
            rd_org  <= WORD_WIDTH_SELECT;
        end else if (state == ST_READ && sk_rise) begin
            if (rd_idx == 4'h0) begin
                rd_idx <= rd_org ? 4'hf : 4'h7;
                if (rd_org) begin
                    rd_addr <= {1'b0, rd_addr[ADDR_W-1:0] + ADDR_W'(1)};
                end else begin
                    rd_addr <= rd_addr + ADDR_MAX_W'(1);
                end
            end else begin
                rd_idx <= rd_idx - 4'h1;
            end
        end
    end

    // Data output pin
    always_ff @(posedge CLK) begin
        if (RST) begin
            SERIAL_DATA_OUT      <= DOUT_RESET;
            SERIAL_DATA_OUT_OE_N <= 1'b1;
        end else if (!CHIP_SELECT) begin
            SERIAL_DATA_OUT_OE_N <= 1'b1;
        end else if (at_addr && opc == OPC_READ) begin
            SERIAL_DATA_OUT      <= 1'b0;
            SERIAL_DATA_OUT_OE_N <= 1'b0;
        end else if (state == ST_READ) begin
            SERIAL_DATA_OUT_OE_N <= 1'b0;
            if (sk_rise) begin
                SERIAL_DATA_OUT <= pick(mif.rdata, rd_addr[0], rd_org,
                                        rd_idx);
            end
        end else if (poll) begin
            SERIAL_DATA_OUT      <= !BUSY;
            SERIAL_DATA_OUT_OE_N <= 1'b0;
        end else begin
            SERIAL_DATA_OUT_OE_N <= 1'b1;
        end
    end
endmodule : sepc_top

// >>> sepc_pkg.sv
/*
 * Shared constants and types of the serial EEPROM program cycle controller.
 * Assumes a 100 MHz system clock and synchronous pin inputs.
 */
package sepc_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROG_TIME_NS  = 5000000;
    localparam int PROG_CYCLES_DFLT = PROG_TIME_NS / CLK_PERIOD_NS;

    localparam int ADDR_W   = 10;
    localparam int DATA_W   = 16;
    localparam int LANES    = DATA_W / 8;
    localparam int MEM_DEPTH = 1 << ADDR_W;
    localparam int ADDR_MAX_W = ADDR_W + 1;
    localparam int SH_W     = 2 + ADDR_MAX_W + DATA_W;

    localparam logic [4:0] ADDR_X16_W = 5'h0a;
    localparam logic [4:0] ADDR_X8_W  = 5'h0b;
    localparam logic [4:0] DATA_X16_W = 5'h10;
    localparam logic [4:0] DATA_X8_W  = 5'h08;
    localparam logic [4:0] OPC_W      = 5'h02;

    localparam logic [1:0] OPC_SPECIAL = 2'h0;
    localparam logic [1:0] OPC_WRITE   = 2'h1;
    localparam logic [1:0] OPC_READ    = 2'h2;
    localparam logic [1:0] OPC_ERASE   = 2'h3;
    localparam logic [1:0] SUB_DISABLE = 2'h0;
    localparam logic [1:0] SUB_WRITE_ALL_CMD    = 2'h1;
    localparam logic [1:0] SUB_ERASE_ALL_CMD    = 2'h2;
    localparam logic [1:0] SUB_ENABLE  = 2'h3;

    localparam logic [1:0] K_WRITE = 2'h0;
    localparam logic [1:0] K_ERASE = 2'h1;
    localparam logic [1:0] K_WRITE_ALL_CMD  = 2'h2;
    localparam logic [1:0] K_ERASE_ALL_CMD  = 2'h3;

    localparam logic WEN_RESET  = 1'b0;
    localparam logic DOUT_RESET = 1'b1;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_SHIFT = 4'h2,
        ST_READ  = 4'h4,
        ST_DONE  = 4'h8
    } sepc_state_e;
endpackage : sepc_pkg

// >>> sepc_mem_if.sv
/*
 * Carrier between the controller and its storage array.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
interface sepc_mem_if;
    import sepc_pkg::*;
    logic              wr_en;
    logic [LANES-1:0]  be;
    logic [ADDR_W-1:0] waddr;
    logic [DATA_W-1:0] wdata;
    logic [ADDR_W-1:0] raddr;
    logic [DATA_W-1:0] rdata;
    modport ctrl (output wr_en, be, waddr, wdata, raddr, input rdata);
    modport mem  (input wr_en, be, waddr, wdata, raddr, output rdata);
endinterface : sepc_mem_if

// >>> sepc_mem.sv
/*
 * Storage array with byte-lane writes and registered read data.
 * Assumes the controller holds read addresses for at least two clocks.
 */
`timescale 1ns/1ps
module sepc_mem
    import sepc_pkg::*;
(
    input wire logic clk,
    sepc_mem_if.mem  bus
);
    logic [DATA_W-1:0] array [MEM_DEPTH];

    // Lane-wise write port
    always_ff @(posedge clk) begin
        for (int b = 0; b < LANES; b++) begin
            if (bus.wr_en && bus.be[b]) begin
                array[bus.waddr][b*8 +: 8] <= bus.wdata[b*8 +: 8];
            end
        end
    end

    // Registered read
    always_ff @(posedge clk) begin
        bus.rdata <= array[bus.raddr];
    end
endmodule : sepc_mem

// >>> sepc_host.sv
/*
 * Host model driving the three-wire serial bus of the EEPROM device.
 * Assumes the bench calls its tasks one at a time from one process.
 */
`timescale 1ns/1ps
module sepc_host
    import sepc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              do_pin,
    output logic                   cs,
    output logic                   sk,
    output logic                   di,
    output logic                   rd_valid,
    output logic [DATA_W-1:0]      rd_word
);
    logic di_r;
    logic junk;
    initial begin
        cs = 1'b0;
        sk = 1'b0;
        di_r = 1'b0;
        junk = 1'b0;
        rd_valid = 1'b0;
        rd_word = '0;
    end
    // Data line is not trusted outside frames, so it toggles there
    always @(posedge clk) junk <= ~junk;
    assign di = cs ? di_r : junk;

    task automatic rise(output logic smp);
        @(posedge clk) sk <= 1'b1;
        repeat (3) @(posedge clk);
        smp = do_pin;
        sk <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : rise

    task automatic frame(input logic [28:0] v, input int n, output logic s);
        @(posedge clk) cs <= 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk) di_r <= v[i];
            rise(s);
        end
    endtask : frame

    task automatic release_cs();
        @(posedge clk) cs <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : release_cs

    task automatic publish(input logic [DATA_W-1:0] w);
        @(posedge clk) rd_valid <= 1'b1;
        rd_word <= w;
        @(posedge clk) rd_valid <= 1'b0;
    endtask : publish

    task automatic read(input logic [ADDR_W-1:0] a);
        logic s;
        logic [DATA_W-1:0] w;
        frame({16'h0, 1'b1, OPC_READ, a}, 13, s);
        publish({15'h0, s});
        di_r <= 1'b0;
        for (int i = 0; i < DATA_W; i++) begin
            rise(s);
            w = {w[DATA_W-2:0], s};
        end
        publish(w);
    endtask : read

    task automatic poll(output logic first, output logic last);
        @(posedge clk) cs <= 1'b1;
        repeat (4) @(posedge clk);
        first = do_pin;
        last = 1'b0;
        for (int i = 0; i < 4000 && !last; i++) @(posedge clk) last = do_pin;
        release_cs();
    endtask : poll
endmodule : sepc_host

// >>> sepc_top_assertions.sv
/*
 * Concurrent checks on the device's pins.
 * Assumes one clock domain with synchronous active-high reset.
 */
`timescale 1ns/1ps
module sepc_top_assertions
    import sepc_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_CYCLES_DFLT
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CHIP_SELECT,
    input wire logic SERIAL_CLOCK_IN,
    input wire logic SERIAL_DATA_IN,
    input wire logic PROGRAM_ENABLE_PIN,
    input wire logic WORD_WIDTH_SELECT,
    input wire logic SERIAL_DATA_OUT,
    input wire logic SERIAL_DATA_OUT_OE_N,
    input wire logic BUSY,
    input wire logic WRITE_ENABLED
);
    logic [31:0] busy_cnt;
    always_ff @(posedge CLK) begin
        if (RST || !BUSY) begin
            busy_cnt <= '0;
        end else begin
            busy_cnt <= busy_cnt + 32'h1;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_reset_idle: assert property ($fell(RST) |-> !BUSY && !WRITE_ENABLED
        && SERIAL_DATA_OUT_OE_N && SERIAL_DATA_OUT) else $error("bad reset");
    a_busy_span: assert property ($fell(BUSY) |->
        busy_cnt == 32'(PROG_CYCLES)) else $error("busy length wrong");
    a_busy_cause: assert property ($rose(BUSY) |-> $past(CHIP_SELECT, 2)
        && !$past(CHIP_SELECT) && $past(WRITE_ENABLED)
        && $past(PROGRAM_ENABLE_PIN)) else $error("busy without start");
    a_latch_refuse: assert property ($fell(CHIP_SELECT) && !BUSY
        && !WRITE_ENABLED |=> !BUSY [*3]) else $error("cycle while off");
    a_pe_refuse: assert property ($fell(CHIP_SELECT) && !BUSY
        && !PROGRAM_ENABLE_PIN |=> !BUSY) else $error("cycle without pe");
    a_latch_hold: assert property ($changed(WRITE_ENABLED) |-> $past(RST)
        || ($past(CHIP_SELECT) && $past(SERIAL_CLOCK_IN)))
        else $error("latch moved outside frame");
    a_poll_busy: assert property (BUSY && $past(BUSY) && $past(BUSY, 2)
        && !SERIAL_DATA_OUT_OE_N |-> !SERIAL_DATA_OUT)
        else $error("ready shown while busy");
    a_oe_deselect: assert property (!CHIP_SELECT [*2] |=>
        SERIAL_DATA_OUT_OE_N) else $error("output driven while deselected");

    c_cycle: cover property ($rose(BUSY));
    c_enable: cover property ($rose(WRITE_ENABLED));
    c_poll: cover property (BUSY && !SERIAL_DATA_OUT_OE_N);
endmodule : sepc_top_assertions

bind sepc_top sepc_top_assertions #(.PROG_CYCLES(PROG_CYCLES))
    sepc_top_assertions_i (.*);

// >>> tb.sv
/*
 * Self-checking bench for the EEPROM device in x16 organisation plus one x8 write.
 * Assumes a short program time so each self-timed cycle is brief.
 */
`timescale 1ns/1ps
module tb;
    import sepc_pkg::*;
    localparam int PROG = 1100;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pe = 1'b0;
    logic word_width_select = 1'b1;
    logic cs, sk, di, dout, oe_n, busy, wen, rd_valid, do_wire, f;
    logic [DATA_W-1:0] rd_word, word, d;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] exp_q[$];
    int mismatches = 0;
    int checks = 0;
    int seed = 32'h6ec48b11;

    always #5 clk = ~clk;
    // Released output line shows the inverse of its last level
    assign do_wire = oe_n ? ~dout : dout;

    sepc_top #(.PROG_CYCLES(PROG)) sepc_top_i (
        .CLK(clk), .RST(rst), .CHIP_SELECT(cs), .SERIAL_CLOCK_IN(sk),
        .SERIAL_DATA_IN(di), .PROGRAM_ENABLE_PIN(pe),
        .WORD_WIDTH_SELECT(word_width_select), .SERIAL_DATA_OUT(dout),
        .SERIAL_DATA_OUT_OE_N(oe_n), .BUSY(busy), .WRITE_ENABLED(wen));
    sepc_host sepc_host_i (.clk(clk), .do_pin(do_wire), .cs(cs), .sk(sk),
        .di(di), .rd_valid(rd_valid), .rd_word(rd_word));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    task automatic prog(input logic [28:0] v, input int n, input logic go);
        logic l;
        sepc_host_i.frame(v, n, f);
        sepc_host_i.release_cs();
        check(16'(busy), 16'(go));
        if (go) begin
            sepc_host_i.poll(f, l);
            check(16'(f), 16'h0);
            check(16'(l), 16'h1);
            check(16'(busy), 16'h0);
        end
    endtask : prog

    task automatic rd(input logic [ADDR_W-1:0] ad, input logic [15:0] e);
        exp_q.push_back(16'h0);
        exp_q.push_back(e);
        sepc_host_i.read(ad);
        sepc_host_i.release_cs();
    endtask : rd

    task automatic latch(input logic [1:0] sub, input logic e);
        sepc_host_i.frame({16'h0, 1'b1, OPC_SPECIAL, sub, 8'h0}, 13, f);
        sepc_host_i.release_cs();
        check(16'(wen), 16'(e));
    endtask : latch

    always @(posedge clk) begin
        if (rd_valid === 1'b1 && exp_q.size() > 0) begin
            check(rd_word, exp_q.pop_front());
        end
    end

    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        summarize();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        check(16'(wen), 16'h0);
        check(16'(oe_n), 16'h1);
        word = 16'($random(seed));
        a = 10'($random(seed));
        d = 16'($random(seed));
        pe <= 1'b1;
        prog({1'b1, OPC_WRITE, 10'h3, d}, 29, 1'b0);
        pe <= 1'b0;
        latch(SUB_ENABLE, 1'b1);
        prog({1'b1, OPC_WRITE, a, d}, 29, 1'b0);
        pe <= 1'b1;
        prog({1'b1, OPC_SPECIAL, SUB_WRITE_ALL_CMD, 8'h0, word}, 29, 1'b1);
        rd(10'h0, word);
        rd(10'h3ff, word);
        prog({1'b1, OPC_WRITE, a, d}, 29, 1'b1);
        rd(a, d);
        rd(a + 10'h1, word);
        prog({16'h0, 1'b1, OPC_ERASE, a}, 13, 1'b1);
        rd(a, 16'hffff);
        prog({1'b1, OPC_WRITE, a, d}, 29, 1'b1);
        prog({16'h0, 1'b1, OPC_SPECIAL, SUB_ERASE_ALL_CMD, 8'h0}, 13, 1'b1);
        rd(a + 10'h1, 16'hffff);
        latch(SUB_DISABLE, 1'b0);
        prog({1'b1, OPC_WRITE, a, d}, 29, 1'b0);
        rd(a, 16'hffff);
        latch(SUB_ENABLE, 1'b1);
        word_width_select <= 1'b0;
        prog({7'h0, 1'b1, OPC_WRITE, a, 1'b1, d[7:0]}, 22, 1'b1);
        word_width_select <= 1'b1;
        rd(a, {d[7:0], 8'hff});
        repeat (4) @(posedge clk);
        check(16'(exp_q.size()), 16'h0);
        summarize();
    end
endmodule : tb
